// file: core/pic_arbiter.sv
// pic_arbiter: picks the winning source by level, then by fixed order
`default_nettype none
module pic_arbiter
(
	// enabled requests and their two-bit levels
	input  wire logic [pic_pkg::NSRC-1:0]   req_i,
	input  wire logic [2*pic_pkg::NSRC-1:0] lvl_i,
	// levels in service, one bit each
	input  wire logic [3:0]                 active_i,
	// winner
	output logic                            grant_o,
	output logic      [3:0]                 grant_idx_o,
	output logic      [1:0]                 grant_lvl_o
);
	logic [pic_pkg::NSRC-1:0] elig;
	logic                     busy;
	logic [1:0]               cur_lvl;

	// highest level now in service
	always_comb
	begin
		busy = |active_i;
		cur_lvl = 2'h0;
		for (int l = 0; l < 4; l++)
			if (active_i[l])
				cur_lvl = 2'(l);
	end

	// only a strictly higher level may cut into a running routine
	genvar g;
	generate
		for (g = 0; g < pic_pkg::NSRC; g++)
		begin : g_elig
			assign elig[g] = req_i[g] && (!busy || lvl_i[2*g+:2] > cur_lvl);
		end
	endgenerate

	// scan from last to first so that on equal level the earlier source wins
	always_comb
	begin
		grant_o = 1'b0;
		grant_idx_o = 4'h0;
		grant_lvl_o = 2'h0;
		for (int i = pic_pkg::NSRC - 1; i >= 0; i--)
			if (elig[i] && (!grant_o || lvl_i[2*i+:2] >= grant_lvl_o))
			begin
				grant_o = 1'b1;
				grant_idx_o = 4'(i);
				grant_lvl_o = lvl_i[2*i+:2];
			end
	end
endmodule
`default_nettype wire

// file: core/pic_ctrl.sv
// pic_ctrl: prioritised interrupt controller, top level
//
// Summary of operation
// - each source takes one of four levels
// - core source level from high/low bit pair
// - extra register holds serial1, serial2 and SPI1 levels
// - only strictly higher level preempts running routine
// - higher level wins among pending requests
// - equal level resolved by fixed polling order
// - latch flags state 2, poll next cycle
// - call pushes PC only, loads fixed vector
// - external input level or falling-edge sensitive
// - external flag cleared on vector only if edge
// - external latency between three and seven cycles
// - timer 0/1 flags cleared on vectoring
// - timer 2 flag hardware clear is configurable
// - serial request is receive OR transmit, software-cleared
// - SPI requests stay pending until software clears
// - software may set or clear every flag except external flags in level mode
// - per-source enables plus one global enable
// - vectoring blocked by level, mid-instruction, return, config write
// - fixed vector address per source
// - return ends routine, releases its level
// - larger two-bit code means higher level
`default_nettype none
module pic_ctrl
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_we_i,
	input  wire logic        reg_re_i,
	output logic      [7:0]  reg_rdata_o,
	// external interrupt pins, active low
	input  wire logic        ext_input_zero_i,
	input  wire logic        ext_input_one_i,
	// peripheral event pulses
	input  wire logic        timer0_rollover_i,
	input  wire logic        timer1_rollover_i,
	input  wire logic        timer2_overflow_i,
	input  wire logic        timer2_external_i,
	input  wire logic [2:0]  rx_done_i,
	input  wire logic [2:0]  tx_done_i,
	input  wire logic [1:0]  spi_done_i,
	// cpu sequencer
	input  wire logic        last_cycle_i,
	input  wire logic        return_from_interrupt_i,
	output logic             call_o,
	output logic      [15:0] call_vector_o,
	output logic      [3:0]  in_service_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic [7:0]               prio_low_q;
	logic [7:0]               prio_high_q;
	logic [7:0]               prio_extra_q;
	logic [7:0]               src_en_q;
	logic [7:0]               src_en2_q;
	logic [7:0]               ctl_q;
	logic [7:0]               flags0_q;
	logic [7:0]               flags0_d;
	logic [7:0]               flags1_q;
	logic [7:0]               flags1_d;
	logic [7:0]               hc0;
	logic [7:0]               hc1;
	logic [7:0]               set0;
	logic [7:0]               set1;
	logic [7:0]               rdata_q;
	logic [1:0]               phase_q;
	logic [1:0]               ext_meta_q;
	logic [1:0]               ext_sync_q;
	logic [1:0]               ext_prev_q;
	logic [1:0]               ext_fall;
	logic [pic_pkg::NSRC-1:0] req;
	logic [pic_pkg::NSRC-1:0] en_vec;
	logic [pic_pkg::NSRC-1:0] sample_q;
	logic [pic_pkg::NSRC-1:0] poll_q;
	logic [pic_pkg::NSRC-1:0] fire_src;
	logic [2*pic_pkg::NSRC-1:0] lvl;
	logic [3:0]               in_service_q;
	logic [3:0]               top_bit;
	logic [1:0]               top_lvl;
	logic                     blk_q;
	logic                     call_q;
	logic [15:0]              vector_q;
	logic [3:0]               call_idx_q;
	logic [1:0]               call_lvl_q;
	logic                     grant;
	logic [3:0]               grant_idx;
	logic [1:0]               grant_lvl;
	logic                     latch_now;
	logic                     poll_now;
	logic                     blocked;
	logic                     vec_fire;
	logic                     wr_plo;
	logic                     wr_phi;
	logic                     wr_pex;
	logic                     wr_en;
	logic                     wr_en2;
	logic                     wr_ctl;
	logic                     wr_f0;
	logic                     wr_f1;
	logic                     wr_cfg;

	// write decode
	assign wr_plo = reg_we_i && (reg_addr_i == pic_pkg::OFS_PRIO_LOW);
	assign wr_phi = reg_we_i && (reg_addr_i == pic_pkg::OFS_PRIO_HIGH);
	assign wr_pex = reg_we_i && (reg_addr_i == pic_pkg::OFS_PRIO_EXT);
	assign wr_en  = reg_we_i && (reg_addr_i == pic_pkg::OFS_EN);
	assign wr_en2 = reg_we_i && (reg_addr_i == pic_pkg::OFS_EN2);
	assign wr_ctl = reg_we_i && (reg_addr_i == pic_pkg::OFS_CTL);
	assign wr_f0  = reg_we_i && (reg_addr_i == pic_pkg::OFS_FLAGS0);
	assign wr_f1  = reg_we_i && (reg_addr_i == pic_pkg::OFS_FLAGS1);
	assign wr_cfg = wr_plo | wr_phi | wr_pex | wr_en | wr_en2;

	// configuration registers; reserved bits are masked and read as zero
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			prio_low_q <= pic_pkg::RST_BYTE;
			prio_high_q <= pic_pkg::RST_BYTE;
			prio_extra_q <= pic_pkg::RST_BYTE;
			src_en_q <= pic_pkg::RST_BYTE;
			src_en2_q <= pic_pkg::RST_BYTE;
			ctl_q <= pic_pkg::RST_BYTE;
		end
		else
		begin
			if (wr_plo)
				prio_low_q <= reg_wdata_i & pic_pkg::MASK_PRIO;
			if (wr_phi)
				prio_high_q <= reg_wdata_i & pic_pkg::MASK_PRIO;
			if (wr_pex)
				prio_extra_q <= reg_wdata_i & pic_pkg::MASK_EXTRA;
			if (wr_en)
				src_en_q <= reg_wdata_i;
			if (wr_en2)
				src_en2_q <= reg_wdata_i & pic_pkg::MASK_EN2;
			if (wr_ctl)
				ctl_q <= reg_wdata_i & pic_pkg::MASK_CTL;
		end
	end

	// machine cycle phase counter, three clocks per machine cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			phase_q <= pic_pkg::PH_FIRST;
		else if (phase_q == pic_pkg::PH_POLL)
			phase_q <= pic_pkg::PH_FIRST;
		else
			phase_q <= phase_q + 2'h1;
	end

	assign latch_now = (phase_q == pic_pkg::PH_LATCH);
	assign poll_now = (phase_q == pic_pkg::PH_POLL);

	// pin synchroniser; idle pins are high
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ext_meta_q <= 2'h3;
			ext_sync_q <= 2'h3;
		end
		else
		begin
			ext_meta_q <= {ext_input_one_i, ext_input_zero_i};
			ext_sync_q <= ext_meta_q;
		end
	end

	// one pin sample per machine cycle; a pulse shorter than that may be missed
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ext_prev_q <= 2'h3;
		else if (latch_now)
			ext_prev_q <= ext_sync_q;
	end

	// high sample then low sample marks a falling transition
	assign ext_fall = latch_now ? (ext_prev_q & ~ext_sync_q) : 2'h0;

	// hardware clear masks, raised only in the vectoring cycle
	always_comb
	begin
		hc0 = 8'h00;
		hc1 = 8'h00;
		hc0[pic_pkg::F0_EXT0] = fire_src[pic_pkg::SRC_EXT0] & ctl_q[pic_pkg::CTL_EXT0_TYPE];
		hc0[pic_pkg::F0_EXT1] = fire_src[pic_pkg::SRC_EXT1] & ctl_q[pic_pkg::CTL_EXT1_TYPE];
		hc0[pic_pkg::F0_T0] = fire_src[pic_pkg::SRC_T0];
		hc0[pic_pkg::F0_T1] = fire_src[pic_pkg::SRC_T1];
		hc0[pic_pkg::F0_T2] = fire_src[pic_pkg::SRC_T2] & ctl_q[pic_pkg::CTL_T2_HWCLR];
		hc1[pic_pkg::F1_TIMER2_EXTERNAL_FLAG] = fire_src[pic_pkg::SRC_T2] & ctl_q[pic_pkg::CTL_T2_HWCLR];
	end

	// hardware set events; serial and spi flags have no hardware clear
	always_comb
	begin
		set0 = 8'h00;
		set1 = 8'h00;
		set0[pic_pkg::F0_EXT0] = ext_fall[0];
		set0[pic_pkg::F0_EXT1] = ext_fall[1];
		set0[pic_pkg::F0_T0] = timer0_rollover_i;
		set0[pic_pkg::F0_T1] = timer1_rollover_i;
		set0[pic_pkg::F0_RX0] = rx_done_i[0];
		set0[pic_pkg::F0_TX0] = tx_done_i[0];
		set0[pic_pkg::F0_SPI0] = spi_done_i[0];
		set0[pic_pkg::F0_T2] = timer2_overflow_i;
		set1[pic_pkg::F1_TIMER2_EXTERNAL_FLAG] = timer2_external_i;
		set1[pic_pkg::F1_RX1] = rx_done_i[1];
		set1[pic_pkg::F1_TX1] = tx_done_i[1];
		set1[pic_pkg::F1_RX2] = rx_done_i[2];
		set1[pic_pkg::F1_TX2] = tx_done_i[2];
		set1[pic_pkg::F1_SPI1] = spi_done_i[1];
	end

	// next flag values: software write replaces, hardware set wins over any clear
	always_comb
	begin
		flags0_d = (wr_f0 ? reg_wdata_i : (flags0_q & ~hc0)) | set0;
		flags1_d = ((wr_f1 ? reg_wdata_i : (flags1_q & ~hc1)) | set1) & pic_pkg::MASK_F1;
		// level mode: the flag simply mirrors the active-low pin
		if (!ctl_q[pic_pkg::CTL_EXT0_TYPE])
			flags0_d[pic_pkg::F0_EXT0] = ~ext_sync_q[0];
		if (!ctl_q[pic_pkg::CTL_EXT1_TYPE])
			flags0_d[pic_pkg::F0_EXT1] = ~ext_sync_q[1];
	end

	// flag registers
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			flags0_q <= pic_pkg::RST_BYTE;
			flags1_q <= pic_pkg::RST_BYTE;
		end
		else
		begin
			flags0_q <= flags0_d;
			flags1_q <= flags1_d;
		end
	end

	// request, enable and level per source
	assign req[pic_pkg::SRC_EXT0] = flags0_q[pic_pkg::F0_EXT0];
	assign req[pic_pkg::SRC_T0] = flags0_q[pic_pkg::F0_T0];
	assign req[pic_pkg::SRC_EXT1] = flags0_q[pic_pkg::F0_EXT1];
	assign req[pic_pkg::SRC_T1] = flags0_q[pic_pkg::F0_T1];
	assign req[pic_pkg::SRC_SER0] = flags0_q[pic_pkg::F0_RX0] | flags0_q[pic_pkg::F0_TX0];
	assign req[pic_pkg::SRC_SPI0] = flags0_q[pic_pkg::F0_SPI0];
	assign req[pic_pkg::SRC_T2] = flags0_q[pic_pkg::F0_T2] | flags1_q[pic_pkg::F1_TIMER2_EXTERNAL_FLAG];
	assign req[pic_pkg::SRC_SER1] = flags1_q[pic_pkg::F1_RX1] | flags1_q[pic_pkg::F1_TX1];
	assign req[pic_pkg::SRC_SER2] = flags1_q[pic_pkg::F1_RX2] | flags1_q[pic_pkg::F1_TX2];
	assign req[pic_pkg::SRC_SPI1] = flags1_q[pic_pkg::F1_SPI1];
	assign en_vec[pic_pkg::SRC_SER1] = src_en2_q[pic_pkg::EN2_SER1];
	assign en_vec[pic_pkg::SRC_SER2] = src_en2_q[pic_pkg::EN2_SER2];
	assign en_vec[pic_pkg::SRC_SPI1] = src_en2_q[pic_pkg::EN2_SPI1];
	assign lvl[2*pic_pkg::SRC_SER1+:2] = prio_extra_q[pic_pkg::PX_SER1+:2];
	assign lvl[2*pic_pkg::SRC_SER2+:2] = prio_extra_q[pic_pkg::PX_SER2+:2];
	assign lvl[2*pic_pkg::SRC_SPI1+:2] = prio_extra_q[pic_pkg::PX_SPI1+:2];

	// core sources share bit positions across enable and priority registers
	genvar g;
	generate
		for (g = 0; g < pic_pkg::NSRC; g++)
		begin : g_src
			if (g < pic_pkg::NCORE)
			begin : g_core
				assign en_vec[g] = src_en_q[g];
				assign lvl[2*g+:2] = {prio_high_q[g], prio_low_q[g]};
			end
			assign fire_src[g] = vec_fire && (grant_idx == 4'(g));
		end
	endgenerate

	// latch all flags in state 2, hand them to the poll of the next machine cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			sample_q <= '0;
			poll_q <= '0;
		end
		else
		begin
			if (latch_now)
				sample_q <= req;
			if (phase_q == pic_pkg::PH_FIRST)
				poll_q <= sample_q;
		end
	end

	// winner among enabled polled requests
	pic_arbiter i_pic_arbiter
	(
		.req_i       (poll_q & en_vec & {pic_pkg::NSRC{src_en_q[pic_pkg::EN_GLOBAL]}}),
		.lvl_i       (lvl),
		.active_i    (in_service_q),
		.grant_o     (grant),
		.grant_idx_o (grant_idx),
		.grant_lvl_o (grant_lvl)
	);

	// return or config write blocks every poll from its own clock through the first final-cycle poll after it
	assign blocked = blk_q | return_from_interrupt_i | wr_cfg;
	assign vec_fire = poll_now && last_cycle_i && !blocked && grant;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			blk_q <= 1'b0;
		else if (return_from_interrupt_i || wr_cfg)
			blk_q <= 1'b1;
		else if (poll_now && last_cycle_i)
			blk_q <= 1'b0;
	end

	// highest level currently in service
	always_comb
	begin
		top_bit = 4'h0;
		top_lvl = 2'h0;
		for (int l = 0; l < 4; l++)
			if (in_service_q[l])
			begin
				top_bit = 4'h1 << l;
				top_lvl = 2'(l);
			end
	end

	// in-service levels: set on vectoring, innermost released by return
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			in_service_q <= 4'h0;
		else if (vec_fire)
			in_service_q <= in_service_q | (4'h1 << grant_lvl);
		else if (return_from_interrupt_i)
			in_service_q <= in_service_q & ~top_bit;
	end

	// call request to the sequencer: only the program counter is pushed
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			call_q <= 1'b0;
			vector_q <= 16'h0000;
			call_idx_q <= 4'h0;
			call_lvl_q <= 2'h0;
		end
		else
		begin
			call_q <= vec_fire;
			if (vec_fire)
			begin
				vector_q <= pic_pkg::VEC[grant_idx];
				call_idx_q <= grant_idx;
				call_lvl_q <= grant_lvl;
			end
		end
	end

	assign call_o = call_q;
	assign call_vector_o = vector_q;
	assign in_service_o = in_service_q;

	// read data stands only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !reg_re_i)
			rdata_q <= 8'h00;
		else
		begin
			unique case (reg_addr_i)
				pic_pkg::OFS_PRIO_LOW:  rdata_q <= prio_low_q;
				pic_pkg::OFS_PRIO_HIGH: rdata_q <= prio_high_q;
				pic_pkg::OFS_PRIO_EXT:  rdata_q <= prio_extra_q;
				pic_pkg::OFS_EN:        rdata_q <= src_en_q;
				pic_pkg::OFS_EN2:       rdata_q <= src_en2_q;
				pic_pkg::OFS_FLAGS0:    rdata_q <= flags0_q;
				pic_pkg::OFS_FLAGS1:    rdata_q <= flags1_q;
				pic_pkg::OFS_CTL:       rdata_q <= ctl_q;
				pic_pkg::OFS_STATUS:    rdata_q <= {call_idx_q, in_service_q};
				default:                rdata_q <= 8'h00;
			endcase
		end
	end

	assign reg_rdata_o = rdata_q;

	// calls leave the poll state, so the next phase is always the first
	AST_POLL_PHASE: assert property (call_o |-> phase_q == pic_pkg::PH_FIRST)
		else $error("call not aligned to poll");

	AST_CALL_LAST: assert property (call_o |-> $past(last_cycle_i) && !$past(blk_q))
		else $error("call outside final unblocked cycle");

	AST_RETURN_FROM_INTERRUPT_BLOCK: assert property ($past(return_from_interrupt_i) |-> !call_o)
		else $error("call during return");

	AST_GLOBAL_EN: assert property (call_o |-> $past(src_en_q[pic_pkg::EN_GLOBAL]))
		else $error("call with global enable off");

	AST_PREEMPT: assert property (call_o |->
		$past(in_service_q) == 4'h0 || call_lvl_q > $past(top_lvl))
		else $error("preempted by equal or lower level");

	AST_RETURN_FROM_INTERRUPT_POP: assert property ((return_from_interrupt_i && !vec_fire) |=>
		in_service_q == ($past(in_service_q) & ~$past(top_bit)))
		else $error("return did not release level");

	AST_EXT0_CLEAR: assert property ((call_o && call_idx_q == pic_pkg::SRC_EXT0
		&& $past(ctl_q[pic_pkg::CTL_EXT0_TYPE]) && !$past(ext_fall[0]) && !$past(wr_f0))
		|-> !flags0_q[pic_pkg::F0_EXT0])
		else $error("edge flag not cleared on vector");

	AST_LEVEL_FOLLOW: assert property (!$past(ctl_q[pic_pkg::CTL_EXT0_TYPE])
		|-> flags0_q[pic_pkg::F0_EXT0] == !$past(ext_sync_q[0]))
		else $error("level flag not following pin");

	AST_T0_CLEAR: assert property ((call_o && call_idx_q == pic_pkg::SRC_T0
		&& !$past(timer0_rollover_i) && !$past(wr_f0)) |-> !flags0_q[pic_pkg::F0_T0])
		else $error("timer 0 flag not cleared");

	AST_SER_KEEP: assert property ((call_o && call_idx_q == pic_pkg::SRC_SER0 && !$past(wr_f0))
		|-> flags0_q[pic_pkg::F0_RX0] || flags0_q[pic_pkg::F0_TX0])
		else $error("serial flag cleared by hardware");
endmodule
`default_nettype wire

// file: core/pic_pkg.sv
// pic_pkg: constants shared by the prioritised interrupt controller
`default_nettype none
package pic_pkg;
	// number of sources, in fixed polling order
	localparam int NSRC = 10;
	localparam logic [3:0] SRC_EXT0 = 4'h0;
	localparam logic [3:0] SRC_T0   = 4'h1;
	localparam logic [3:0] SRC_EXT1 = 4'h2;
	localparam logic [3:0] SRC_T1   = 4'h3;
	localparam logic [3:0] SRC_SER0 = 4'h4;
	localparam logic [3:0] SRC_SPI0 = 4'h5;
	localparam logic [3:0] SRC_T2   = 4'h6;
	localparam logic [3:0] SRC_SER1 = 4'h7;
	localparam logic [3:0] SRC_SER2 = 4'h8;
	localparam logic [3:0] SRC_SPI1 = 4'h9;
	// sources whose level comes from the high/low priority pair
	localparam int NCORE = 7;

	// register offsets
	localparam logic [7:0] OFS_PRIO_LOW  = 8'h00;
	localparam logic [7:0] OFS_PRIO_HIGH = 8'h01;
	localparam logic [7:0] OFS_PRIO_EXT  = 8'h02;
	localparam logic [7:0] OFS_EN        = 8'h03;
	localparam logic [7:0] OFS_EN2       = 8'h04;
	localparam logic [7:0] OFS_FLAGS0    = 8'h05;
	localparam logic [7:0] OFS_FLAGS1    = 8'h06;
	localparam logic [7:0] OFS_CTL       = 8'h07;
	localparam logic [7:0] OFS_STATUS    = 8'h08;

	// reset value and masks of implemented bits
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [7:0] MASK_PRIO  = 8'h7F;
	localparam logic [7:0] MASK_EXTRA = 8'hF3;
	localparam logic [7:0] MASK_EN2   = 8'h0B;
	localparam logic [7:0] MASK_F1    = 8'h3F;
	localparam logic [7:0] MASK_CTL   = 8'h07;

	// field positions
	localparam int EN_GLOBAL = 7;
	localparam int EN2_SER1  = 0;
	localparam int EN2_SER2  = 1;
	localparam int EN2_SPI1  = 3;
	localparam int PX_SER1   = 0;
	localparam int PX_SER2   = 4;
	localparam int PX_SPI1   = 6;
	localparam int CTL_EXT0_TYPE = 0;
	localparam int CTL_EXT1_TYPE = 1;
	localparam int CTL_T2_HWCLR  = 2;
	localparam int F0_EXT0 = 0;
	localparam int F0_T0   = 1;
	localparam int F0_EXT1 = 2;
	localparam int F0_T1   = 3;
	localparam int F0_RX0  = 4;
	localparam int F0_TX0  = 5;
	localparam int F0_SPI0 = 6;
	localparam int F0_T2   = 7;
	localparam int F1_TIMER2_EXTERNAL_FLAG = 0;
	localparam int F1_RX1  = 1;
	localparam int F1_TX1  = 2;
	localparam int F1_RX2  = 3;
	localparam int F1_TX2  = 4;
	localparam int F1_SPI1 = 5;

	// machine cycle of three clocks: flags latched in state 2, polled at state 3
	localparam logic [1:0] PH_FIRST = 2'h0;
	localparam logic [1:0] PH_LATCH = 2'h1;
	localparam logic [1:0] PH_POLL  = 2'h2;

	// fixed entry address per source
	localparam logic [15:0] VEC [0:NSRC-1] = '{
		16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
		16'h002B, 16'h0033, 16'h003B, 16'h004B, 16'h0053
	};
endpackage
`default_nettype wire

// file: test/pic_cpu_model.sv
// pic_cpu_model: sequencer stand-in driving final-cycle and return signals
`default_nettype none
module pic_cpu_model
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// bench control
	input  wire logic slow_i,
	input  wire logic return_from_interrupt_req_i,
	// towards the controller
	output logic      last_cycle_o,
	output logic      return_from_interrupt_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [1:0] ph_q;
	logic       odd_q;

	// three clocks per machine cycle; slow mode runs two-cycle instructions
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ph_q  <= 2'h0;
			odd_q <= 1'b0;
		end
		else
		begin
			ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
			if (ph_q == 2'h2)
				odd_q <= ~odd_q;
		end
	end

	// only the final cycle of an instruction may be polled
	assign last_cycle_o = !slow_i || odd_q;

	// return executes as a one-clock pulse
	always_ff @(posedge clk_i)
	begin
		return_from_interrupt_o <= rst_n_i && return_from_interrupt_req_i;
	end
endmodule
`default_nettype wire

// file: test/tb_pic_ctrl.sv
// tb_pic_ctrl: self-checking bench for the interrupt controller
`default_nettype none
module tb_pic_ctrl;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [15:0] VTAB [10] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B,
		16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h004B, 16'h0053};
	// {flags1, flags0} bits owned by each source
	localparam logic [15:0] FMASK [10] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008,
		16'h0030, 16'h0040, 16'h0180, 16'h0600, 16'h1800, 16'h2000};

	logic        clk, rst_n, we, re, pin0, pin1, t0, t1, t2o, t2e;
	logic        last_cycle, return_from_interrupt, return_from_interrupt_req, slow, call, re_seen;
	logic [7:0]  addr, wdata, rdata, lo, hi, ex, f0, f1;
	logic [2:0]  rx, tx;
	logic [1:0]  spi;
	logic [15:0] vec;
	logic [3:0]  insvc;
	logic [1:0]  lv [10];
	logic [7:0]  rq [$];
	logic [15:0] cq [$];
	int          oq [$];
	int          errors, checks, ncall, nseen;

	always #50 clk = ~clk;

	pic_ctrl i_pic_ctrl (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
		.ext_input_zero_i(pin0), .ext_input_one_i(pin1), .timer0_rollover_i(t0),
		.timer1_rollover_i(t1), .timer2_overflow_i(t2o), .timer2_external_i(t2e),
		.rx_done_i(rx), .tx_done_i(tx), .spi_done_i(spi), .last_cycle_i(last_cycle),
		.return_from_interrupt_i(return_from_interrupt), .call_o(call), .call_vector_o(vec), .in_service_o(insvc));
	pic_cpu_model i_pic_cpu_model (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow),
		.return_from_interrupt_req_i(return_from_interrupt_req), .last_cycle_o(last_cycle), .return_from_interrupt_o(return_from_interrupt));

	task automatic close_out();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// result watcher: oldest note against each read answer and each call
	always @(posedge clk)
	begin
		if (re_seen)
			chk8(rdata, rq.size() != 0 ? rq.pop_front() : 8'hxx);
		re_seen <= re;
		if (call === 1'b1)
		begin
			ncall++;
			chk16(vec, cq.size() != 0 ? cq.pop_front() : 16'hxxxx);
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		we    <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		@(posedge clk);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
	endtask

	// one-clock peripheral events {t0, t1, t2o, t2e, rx, tx, spi}
	task automatic ev(input logic [11:0] v);
		@(posedge clk);
		{t0, t1, t2o, t2e, rx, tx, spi} <= v;
		@(posedge clk);
		{t0, t1, t2o, t2e, rx, tx, spi} <= 12'h000;
	endtask

	// bounded wait for the next call
	task automatic nxt();
		int k;
		k = 0;
		while (ncall <= nseen && k < 600)
		begin
			@(posedge clk);
			k++;
		end
		if (ncall <= nseen)
			errors++;
		nseen++;
	endtask

	// settle two machine cycles so software clears are sampled first
	task automatic ret();
		repeat (6) @(posedge clk);
		return_from_interrupt_req <= 1'b1;
		@(posedge clk);
		return_from_interrupt_req <= 1'b0;
	endtask

	// overall time limit, far beyond the expected run
	initial
	begin
		#(20000 * 100);
		errors++;
		close_out();
	end

	initial
	begin
		clk = 0; rst_n = 0; we = 0; re = 0; re_seen = 0; return_from_interrupt_req = 0; slow = 0;
		addr = 0; wdata = 0; pin0 = 1; pin1 = 1; {t0, t1, t2o, t2e, rx, tx, spi} = 0;
		errors = 0; checks = 0; ncall = 0; nseen = 0;
		void'($urandom(32'h9270));
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 10; a++)
			rd(8'(a), 8'h00);
		// equal level waits, higher level preempts
		wr(pic_pkg::OFS_PRIO_LOW, 8'h0A);
		wr(pic_pkg::OFS_PRIO_HIGH, 8'h04);
		wr(pic_pkg::OFS_CTL, 8'h03);
		wr(pic_pkg::OFS_EN, 8'h8E);
		slow <= 1'b1;
		cq = {cq, 16'h001B, 16'h0013, 16'h000B};
		ev(12'h400);
		nxt();
		ev(12'h800);
		repeat (30) @(posedge clk);
		pin1 <= 1'b0;
		repeat (6) @(posedge clk);
		pin1 <= 1'b1;
		nxt();
		rd(pic_pkg::OFS_STATUS, 8'h26);
		chk8({4'h0, insvc}, 8'h06);
		ret();
		ret();
		nxt();
		ret();
		slow <= 1'b0;
		// level mode: a held request is served again
		wr(pic_pkg::OFS_CTL, 8'h00);
		wr(pic_pkg::OFS_EN, 8'h81);
		cq = {cq, 16'h0003, 16'h0003};
		pin0 <= 1'b0;
		nxt();
		ret();
		nxt();
		pin0 <= 1'b1;
		repeat (9) @(posedge clk);
		ret();
		// timer 2 clear by software, then by hardware
		wr(pic_pkg::OFS_CTL, 8'h03);
		wr(pic_pkg::OFS_EN, 8'hC0);
		cq = {cq, 16'h0033, 16'h0033, 16'h0033};
		ev(12'h200);
		nxt();
		ret();
		nxt();
		wr(pic_pkg::OFS_FLAGS0, 8'h00);
		ret();
		wr(pic_pkg::OFS_CTL, 8'h07);
		ev(12'h100);
		nxt();
		ret();
		repeat (30) @(posedge clk);
		// random levels, every source pending at once behind the global gate
		wr(pic_pkg::OFS_EN2, 8'h0B);
		for (int r = 0; r < 3; r++)
		begin
			lo = 8'($urandom());
			hi = 8'($urandom());
			ex = 8'($urandom());
			wr(pic_pkg::OFS_EN, 8'h7F);
			wr(pic_pkg::OFS_PRIO_LOW, lo);
			wr(pic_pkg::OFS_PRIO_HIGH, hi);
			wr(pic_pkg::OFS_PRIO_EXT, ex);
			rd(pic_pkg::OFS_PRIO_LOW, lo & 8'h7F);
			rd(pic_pkg::OFS_PRIO_HIGH, hi & 8'h7F);
			rd(pic_pkg::OFS_PRIO_EXT, ex & 8'hF3);
			for (int i = 0; i < 7; i++)
				lv[i] = {hi[i], lo[i]};
			lv[7] = ex[1:0];
			lv[8] = ex[5:4];
			lv[9] = ex[7:6];
			oq.delete();
			for (int l = 3; l >= 0; l--)
				for (int i = 0; i < 10; i++)
					if (int'(lv[i]) == l)
						oq.push_back(i);
			foreach (oq[j])
				cq.push_back(VTAB[oq[j]]);
			pin0 <= 1'b0;
			pin1 <= 1'b0;
			ev(12'hEAB);
			repeat (4) @(posedge clk);
			pin0 <= 1'b1;
			pin1 <= 1'b1;
			f0 = 8'hDF;
			f1 = 8'h2C;
			repeat (9) @(posedge clk);
			wr(pic_pkg::OFS_EN, 8'hFF);
			for (int j = 0; j < 10; j++)
			begin
				nxt();
				chk8({4'h0, insvc}, 8'h01 << lv[oq[j]]);
				{f1, f0} = {f1, f0} & ~FMASK[oq[j]];
				wr(pic_pkg::OFS_FLAGS0, f0);
				wr(pic_pkg::OFS_FLAGS1, f1);
				ret();
			end
		end
		// software raises a request; it stays pending after the call
		cq.push_back(16'h0053);
		wr(pic_pkg::OFS_FLAGS1, 8'h20);
		nxt();
		rd(pic_pkg::OFS_FLAGS1, 8'h20);
		wr(pic_pkg::OFS_FLAGS1, 8'h00);
		ret();
		// reset in mid-service
		cq.push_back(16'h000B);
		ev(12'h800);
		nxt();
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		chk8({4'h0, insvc}, 8'h00);
		rd(pic_pkg::OFS_STATUS, 8'h00);
		repeat (4) @(posedge clk);
		chk16(16'(cq.size()), 16'h0000);
		close_out();
	end
endmodule
`default_nettype wire
